/* File: core/ofr_fault_ctrl.sv */
// over-voltage fault response and restart controller
//
// How it works
// - every fault edge drives alert low and sets the fault flag.
// - response 00 keeps the output on, only signalling the fault.
// - response 01 keeps running for time field times 10 ms unit.
// - if fault remains after that delay, follow the retry setting.
// - response 10 shuts the output at once, then follows retry setting.
// - response 11 holds output off while fault persists, then resumes.
// - retry setting gives the number of restart attempts after shutdown.
// - retry 000 means no restart; output stays off until cleared.
// - retry 001 allows one attempt; failure latches output off.
// - attempt starts are spaced by time field times retry unit.
// - retry 010 to 110 give 2 to 6 attempts, then stay off.
// - retry 111 retries forever until disabled or another fault stops it.
// - units are 10 ms for operate delay and 8.2 ms for retry spacing.
`timescale 1ns/100ps
module ofr_fault_ctrl #(
  parameter int unsigned OPERATE_CYC = ofr_pkg::OPERATE_UNIT_CYC,
  parameter int unsigned RETRY_CYC   = ofr_pkg::RETRY_UNIT_CYC
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic                ov_fault_in,
  input  wire logic                cfg_wr,
  input  wire logic [7:0]          cfg_wdata,
  output logic [7:0]               cfg_rdata,
  input  wire logic                fault_clear,
  input  wire logic                retry_abort,
  output logic                     output_enable,
  output logic                     alert_out_n,
  output ofr_pkg::ofr_status_t     status
);

  localparam int unsigned TW = ofr_pkg::TIMER_W;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // seven units must fit the timer, and a zero unit would cut
  // every delay down to one cycle
  if (OPERATE_CYC == 0 || RETRY_CYC == 0) begin : g_unit_zero
    $error("delay unit must be at least one cycle");
  end
  if (64'(OPERATE_CYC) * 7 >= (64'd1 << TW) ||
      64'(RETRY_CYC) * 7 >= (64'd1 << TW)) begin : g_unit_wide
    $error("delay unit too large for timer width");
  end

  // ---------------------------------------------------------------
  // fault input synchroniser
  // ---------------------------------------------------------------
  // the detector is analog and asynchronous to mclk
  logic sync1_reg;
  logic sync2_reg;
  logic fault_prev_reg;
  logic fault_now;
  logic fault_rise;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync1_reg      <= 1'b0;
      sync2_reg      <= 1'b0;
      fault_prev_reg <= 1'b0;
    end else begin
      sync1_reg      <= ov_fault_in;
      sync2_reg      <= sync1_reg;
      fault_prev_reg <= sync2_reg;
    end
  end

  assign fault_now  = sync2_reg;
  assign fault_rise = sync2_reg & ~fault_prev_reg;

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  ofr_pkg::ofr_action_t action_reg;
  ofr_pkg::ofr_action_t action_next;

  always_comb begin
    action_next = action_reg;
    if (cfg_wr) begin
      action_next = ofr_pkg::ofr_action_t'(cfg_wdata);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      action_reg <= ofr_pkg::ofr_action_t'(ofr_pkg::ACTION_RST);
    end else begin
      action_reg <= action_next;
    end
  end

  assign cfg_rdata = action_reg;

  // ---------------------------------------------------------------
  // delay timer
  // ---------------------------------------------------------------
  logic          tmr_start;
  logic [TW-1:0] tmr_load;
  logic          tmr_expired;

  ofr_timer #(
    .WIDTH    (TW)
  ) u_timer (
    .mclk     (mclk),
    .resetn   (resetn),
    .start    (tmr_start),
    .load_val (tmr_load),
    .expired  (tmr_expired),
    .running  ()
  );

  // ---------------------------------------------------------------
  // response sequencer
  // ---------------------------------------------------------------
  ofr_pkg::ofr_state_t  state_reg;
  ofr_pkg::ofr_state_t  state_next;
  ofr_pkg::ofr_action_t active_reg;
  ofr_pkg::ofr_action_t active_next;
  logic [2:0]           left_reg;
  logic [2:0]           left_next;
  logic                 flag_reg;
  logic                 flag_next;
  logic                 out_on_reg;
  logic                 out_on_next;
  logic                 alert_n_reg;
  logic                 alert_n_next;
  logic [TW-1:0]        retry_gap;
  logic [TW-1:0]        operate_gap;
  logic                 forever_retry;

  // products stay below 2**TW, as checked above
  assign retry_gap   = TW'(RETRY_CYC) * TW'(active_next.rtime);
  assign operate_gap = TW'(OPERATE_CYC) * TW'(action_reg.rtime);
  assign forever_retry = (active_reg.retries == ofr_pkg::RETRY_FOREVER);

  always_comb begin
    state_next  = state_reg;
    active_next = active_reg;
    left_next   = left_reg;
    out_on_next = out_on_reg;
    tmr_start   = 1'b0;
    tmr_load    = retry_gap;

    case (state_reg)
      ofr_pkg::ST_IDLE: begin
        out_on_next = 1'b1;
        if (fault_rise) begin
          // snapshot so later writes only touch the next fault
          active_next = action_reg;
          case (action_reg.resp)
            ofr_pkg::OFR_IGNORE: begin
              state_next = ofr_pkg::ST_IDLE;
            end
            ofr_pkg::OFR_OPERATE: begin
              state_next = ofr_pkg::ST_OPERATE;
              tmr_start  = 1'b1;
              tmr_load   = operate_gap;
            end
            ofr_pkg::OFR_DISABLE: begin
              out_on_next = 1'b0;
              left_next   = action_reg.retries;
              if (action_reg.retries == ofr_pkg::RETRY_NONE) begin
                state_next = ofr_pkg::ST_LATCHED;
              end else begin
                state_next = ofr_pkg::ST_OFFWAIT;
                tmr_start  = 1'b1;
              end
            end
            default: begin
              out_on_next = 1'b0;
              state_next  = ofr_pkg::ST_HOLD;
            end
          endcase
        end
      end

      ofr_pkg::ST_OPERATE: begin
        if (tmr_expired) begin
          if (!fault_now) begin
            state_next = ofr_pkg::ST_IDLE;
          end else begin
            out_on_next = 1'b0;
            left_next   = active_reg.retries;
            if (active_reg.retries == ofr_pkg::RETRY_NONE) begin
              state_next = ofr_pkg::ST_LATCHED;
            end else begin
              state_next = ofr_pkg::ST_OFFWAIT;
              tmr_start  = 1'b1;
            end
          end
        end
      end

      ofr_pkg::ST_OFFWAIT: begin
        out_on_next = 1'b0;
        if (tmr_expired) begin
          // attempt start; the next start is one gap later
          state_next  = ofr_pkg::ST_ATTEMPT;
          out_on_next = 1'b1;
          tmr_start   = 1'b1;
          if (!forever_retry) begin
            left_next = left_reg - 3'h1;
          end
        end
      end

      ofr_pkg::ST_ATTEMPT: begin
        if (fault_now) begin
          // failed attempt; timer keeps running for the spacing
          out_on_next = 1'b0;
          if (forever_retry || left_reg != 3'h0) begin
            state_next = ofr_pkg::ST_OFFWAIT;
          end else begin
            state_next = ofr_pkg::ST_LATCHED;
          end
        end else if (tmr_expired) begin
          state_next = ofr_pkg::ST_IDLE;
        end
      end

      // latched off; only the host clear brings the output back,
      // one edge after the clear is taken
      ofr_pkg::ST_LATCHED: begin
        out_on_next = 1'b0;
        if (fault_clear) begin
          state_next = ofr_pkg::ST_IDLE;
        end
      end

      // no retry count here: the output follows the fault level,
      // so a chattering fault chatters the output as well
      ofr_pkg::ST_HOLD: begin
        out_on_next = 1'b0;
        if (!fault_now) begin
          state_next  = ofr_pkg::ST_IDLE;
          out_on_next = 1'b1;
        end
      end

      default: begin
        state_next  = ofr_pkg::ST_IDLE;
        out_on_next = 1'b1;
      end
    endcase

    // host disable or another shutdown ends any restart activity;
    // the enclosing power stage owns the output after that
    if (retry_abort &&
        (state_reg == ofr_pkg::ST_OFFWAIT ||
         state_reg == ofr_pkg::ST_ATTEMPT)) begin
      state_next  = ofr_pkg::ST_LATCHED;
      out_on_next = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // fault flag and alert
  // ---------------------------------------------------------------
  // a fault edge in the clearing cycle wins over the clear
  always_comb begin
    flag_next = flag_reg;
    if (fault_clear) begin
      flag_next = 1'b0;
    end
    if (fault_rise) begin
      flag_next = 1'b1;
    end
    alert_n_next = ~flag_next;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg   <= ofr_pkg::ST_IDLE;
      active_reg  <= ofr_pkg::ofr_action_t'(ofr_pkg::ACTION_RST);
      left_reg    <= 3'h0;
      flag_reg    <= 1'b0;
      out_on_reg  <= 1'b1;
      alert_n_reg <= 1'b1;
    end else begin
      state_reg   <= state_next;
      active_reg  <= active_next;
      left_reg    <= left_next;
      flag_reg    <= flag_next;
      out_on_reg  <= out_on_next;
      alert_n_reg <= alert_n_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign output_enable        = out_on_reg;
  assign alert_out_n          = alert_n_reg;
  assign status.fault_flag    = flag_reg;
  assign status.output_on     = out_on_reg;
  assign status.attempts_left = left_reg;

endmodule : ofr_fault_ctrl

/* File: core/ofr_pkg.sv */
// shared constants and types for the over-voltage fault response block
package ofr_pkg;

  // ---------------------------------------------------------------
  // clock and delay units
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ          = 125000;
  // continued-operation unit, microseconds
  localparam int unsigned OPERATE_UNIT_US  = 10000;
  // spacing unit between restart attempts, tenths of a millisecond
  localparam int unsigned RETRY_UNIT_TMS   = 82;
  localparam int unsigned OPERATE_UNIT_CYC = OPERATE_UNIT_US * CLK_KHZ / 1000;
  localparam int unsigned RETRY_UNIT_CYC   = RETRY_UNIT_TMS * CLK_KHZ / 10;
  localparam int unsigned TIMER_W          = 24;

  // ---------------------------------------------------------------
  // configuration register layout
  // ---------------------------------------------------------------
  localparam int unsigned RESP_LSB   = 6;
  localparam int unsigned RETRY_LSB  = 3;
  localparam int unsigned RTIME_LSB  = 0;
  localparam logic [7:0]  ACTION_RST = 8'h80;

  typedef enum logic [1:0] {
    OFR_IGNORE   = 2'h0,
    OFR_OPERATE  = 2'h1,
    OFR_DISABLE  = 2'h2,
    OFR_UNTIL_OK = 2'h3
  } ofr_resp_t;

  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  typedef struct packed {
    ofr_resp_t  resp;
    logic [2:0] retries;
    logic [2:0] rtime;
  } ofr_action_t;

  typedef struct packed {
    logic       fault_flag;
    logic       output_on;
    logic [2:0] attempts_left;
  } ofr_status_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_OPERATE = 3'h1,
    ST_OFFWAIT = 3'h2,
    ST_ATTEMPT = 3'h3,
    ST_LATCHED = 3'h4,
    ST_HOLD    = 3'h5
  } ofr_state_t;

endpackage : ofr_pkg

/* File: core/ofr_timer.sv */
// one-shot down counter used for operate and retry delays
`timescale 1ns/100ps
module ofr_timer #(
  parameter int unsigned WIDTH = ofr_pkg::TIMER_W
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load_val,
  output logic                  expired,
  output logic                  running
);

  // the compare against one needs at least two counter bits
  if (WIDTH < 2) begin : g_bad_width
    $error("timer width must be at least 2");
  end

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             run_reg;
  logic             run_next;
  logic             exp_reg;
  logic             exp_next;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // a load of zero or one expires on the next edge, so a zero
  // field still gives a one-cycle gap rather than a stuck timer
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    exp_next = 1'b0;
    if (start) begin
      cnt_next = load_val;
      run_next = 1'b1;
    end else if (run_reg) begin
      if (cnt_reg <= WIDTH'(1)) begin
        cnt_next = '0;
        run_next = 1'b0;
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - WIDTH'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      exp_reg <= exp_next;
    end
  end

  assign expired = exp_reg;
  assign running = run_reg;

endmodule : ofr_timer

/* File: test/ofr_host_model.sv */
// host model: writes the action register and clears faults
`timescale 1ns/100ps
module ofr_host_model (
  input  wire logic       mclk,
  output logic            cfg_wr,
  output logic [7:0]      cfg_wdata,
  output logic            fault_clear
);
  initial begin
    cfg_wr      = 1'b0;
    cfg_wdata   = 8'h00;
    fault_clear = 1'b0;
  end

  // called at a falling edge; released data is inverted, never left stale
  task automatic write_cfg(input logic [7:0] v);
    cfg_wr    = 1'b1;
    cfg_wdata = v;
    @(negedge mclk);
    cfg_wr    = 1'b0;
    cfg_wdata = ~v;
  endtask : write_cfg

  task automatic clear_fault;
    fault_clear = 1'b1;
    @(negedge mclk);
    fault_clear = 1'b0;
  endtask : clear_fault
endmodule : ofr_host_model

/* File: test/ofr_fault_ctrl_chk.sv */
// checker: port assertions for the fault response controller
`timescale 1ns/100ps
module ofr_fault_ctrl_chk #(
  parameter int unsigned OPERATE_CYC = ofr_pkg::OPERATE_UNIT_CYC,
  parameter int unsigned RETRY_CYC   = ofr_pkg::RETRY_UNIT_CYC
) (
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 ov_fault_in,
  input wire logic                 cfg_wr,
  input wire logic [7:0]           cfg_wdata,
  input wire logic [7:0]           cfg_rdata,
  input wire logic                 fault_clear,
  input wire logic                 output_enable,
  input wire logic                 alert_out_n,
  input wire ofr_pkg::ofr_status_t status
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  if (OPERATE_CYC < 4 || RETRY_CYC == 0) begin : g_unit_short
    $error("operate unit below 4 cycles or zero retry unit");
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_reg;
    cfg_wr |=> cfg_rdata == $past(cfg_wdata);
  endproperty
  a_reg: assert property (p_reg) else $error("readback wrong");

  // the synchroniser needs three edges after reset to see a rise
  property p_alert;
    $rose(ov_fault_in) && $past(resetn, 3)
      |-> ##3 !alert_out_n && status.fault_flag;
  endproperty
  a_alert: assert property (p_alert) else $error("no alert");

  property p_hold;
    !alert_out_n && !fault_clear |=> !alert_out_n;
  endproperty
  a_hold: assert property (p_hold) else $error("alert lost");

  property p_clr;
    fault_clear && !alert_out_n
      && !(ov_fault_in || $past(ov_fault_in) || $past(ov_fault_in, 2))
      |=> alert_out_n && !status.fault_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");

  property p_ign;
    $rose(ov_fault_in) && cfg_rdata[7:6] == 2'h0 && output_enable
      |-> output_enable [*8];
  endproperty
  a_ign: assert property (p_ign) else $error("output cut");

  // holds only while the operate unit is at least 4 cycles
  property p_opr;
    $rose(ov_fault_in) && cfg_rdata[7:6] == 2'h1 && cfg_rdata[2:0] > 3'h1
      && output_enable |-> output_enable [*8];
  endproperty
  a_opr: assert property (p_opr) else $error("early stop");

  property p_off;
    $rose(ov_fault_in) && cfg_rdata[7] && output_enable && $past(resetn, 3)
      |-> ##3 !output_enable;
  endproperty
  a_off: assert property (p_off) else $error("no shutdown");

  property p_res;
    $fell(ov_fault_in) && cfg_rdata[7:6] == 2'h3 && !output_enable
      |-> ##3 output_enable;
  endproperty
  a_res: assert property (p_res) else $error("no resume");

  property p_lat;
    !output_enable && status.attempts_left == 3'h0
      && cfg_rdata[7:6] == 2'h2 && !fault_clear && !$past(fault_clear)
      |=> !output_enable;
  endproperty
  a_lat: assert property (p_lat) else $error("latch left");

  c_try: cover property ($rose(output_enable) && !alert_out_n);
  c_clr: cover property (fault_clear && !alert_out_n);
  c_hld: cover property (!output_enable && cfg_rdata[7:6] == 2'h3);
endmodule : ofr_fault_ctrl_chk

bind ofr_fault_ctrl ofr_fault_ctrl_chk #(
  .OPERATE_CYC(OPERATE_CYC), .RETRY_CYC(RETRY_CYC)
) ofr_fault_ctrl_chk_inst (
  .mclk(mclk), .resetn(resetn), .ov_fault_in(ov_fault_in),
  .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .fault_clear(fault_clear), .output_enable(output_enable),
  .alert_out_n(alert_out_n), .status(status)
);

/* File: test/test_ofr_fault_ctrl.sv */
// self-checking bench for the fault response controller
`timescale 1ns/100ps
module test_ofr_fault_ctrl;
  typedef struct {int c; logic [1:0] v;} ofr_ev_t;
  logic                 mclk, resetn, ov_fault_in, retry_abort;
  logic                 cfg_wr, fault_clear, output_enable, alert_out_n;
  logic [7:0]           cfg_wdata, cfg_rdata, r;
  logic [1:0]           last;
  ofr_pkg::ofr_status_t status;
  int                   cyc, b, num_errors, checked;
  ofr_ev_t              q[$];

  ofr_fault_ctrl #(.OPERATE_CYC(4), .RETRY_CYC(3)) ofr_fault_ctrl_inst (
    .mclk(mclk), .resetn(resetn), .ov_fault_in(ov_fault_in),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .fault_clear(fault_clear), .retry_abort(retry_abort),
    .output_enable(output_enable), .alert_out_n(alert_out_n),
    .status(status));
  ofr_host_model ofr_host_model_inst (
    .mclk(mclk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .fault_clear(fault_clear));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic chk_val(string nm, logic [7:0] e, logic [7:0] s);
    checked++;
    if (e !== s) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk_val
  // {output_enable, alert_out_n} change and the edge it landed on
  task automatic chk_ev(ofr_ev_t e, logic [1:0] s);
    checked++;
    if (e.c != cyc || e.v !== s) begin
      num_errors++;
      $display("unexpected event: expected %0d/%b seen %0d/%b",
               e.c, e.v, cyc, s);
    end
  endtask : chk_ev
  task automatic idle(int k);
    repeat (k) @(negedge mclk);
  endtask : idle
  task automatic ex(int d, logic [1:0] v);
    q.push_back('{b + d, v});
  endtask : ex
  task automatic fault(logic v);
    @(negedge mclk);
    ov_fault_in = v;
    b = cyc + 1;
  endtask : fault
  task automatic cfg(logic [7:0] v);
    @(negedge mclk);
    ofr_host_model_inst.write_cfg(v);
  endtask : cfg
  // a latched output comes back one edge after the alert is released
  task automatic clr(logic lat);
    @(negedge mclk);
    b = cyc + 1;
    if (lat) begin
      ex(0, 2'b01);
      ex(1, 2'b11);
    end else begin
      ex(0, 2'b11);
    end
    ofr_host_model_inst.clear_fault();
  endtask : clr

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  always @(negedge mclk) begin
    if (resetn && {output_enable, alert_out_n} !== last) begin
      last = {output_enable, alert_out_n};
      if (q.size() == 0) chk_ev('{-1, 2'bxx}, last);
      else chk_ev(q.pop_front(), last);
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    ov_fault_in = 1'b0;
    retry_abort = 1'b0;
    last = 2'b11;
    void'($urandom(32'h48f9fd6c));
    idle(8);
    chk_val("reset cfg", 8'h80, cfg_rdata);
    resetn = 1'b1;
    idle(3);
    repeat (6) begin
      r = 8'($urandom);
      cfg(r);
      idle(1);
      chk_val("cfg", r, cfg_rdata);
    end
    cfg(8'h09);
    fault(1'b1);
    ex(2, 2'b10);
    idle(5);
    chk_val("flag", 8'h01, {7'h0, status.fault_flag});
    fault(1'b0);
    idle(4);
    clr(1'b0);
    cfg(8'hc0);
    fault(1'b1);
    ex(2, 2'b00);
    idle(9);
    fault(1'b0);
    ex(2, 2'b10);
    idle(5);
    clr(1'b0);
    cfg(8'h91);
    fault(1'b1);
    ex(2, 2'b00);
    ex(6, 2'b10);
    ex(7, 2'b00);
    ex(10, 2'b10);
    ex(11, 2'b00);
    idle(6);
    cfg(8'h00);
    idle(12);
    chk_val("status", 8'h10, 8'(status));
    fault(1'b0);
    idle(4);
    clr(1'b1);
    cfg(8'h80);
    fault(1'b1);
    ex(2, 2'b00);
    idle(4);
    fault(1'b0);
    idle(20);
    clr(1'b1);
    cfg(8'h4a);
    fault(1'b1);
    ex(2, 2'b10);
    ex(11, 2'b00);
    ex(18, 2'b10);
    ex(19, 2'b00);
    idle(22);
    fault(1'b0);
    idle(4);
    clr(1'b1);
    cfg(8'hb9);
    fault(1'b1);
    ex(2, 2'b00);
    for (int i = 0; i < 8; i++) begin
      ex(6 + 4 * i, 2'b10);
      ex(7 + 4 * i, 2'b00);
    end
    // abort lands in the off gap after the eighth failed attempt
    idle(37);
    retry_abort = 1'b1;
    idle(2);
    retry_abort = 1'b0;
    chk_val("status", 8'h17, 8'(status));
    fault(1'b0);
    idle(6);
    clr(1'b1);
    idle(10);
    chk_val("pending", 8'h00, 8'(q.size()));
    report_and_stop();
  end
endmodule : test_ofr_fault_ctrl
